// ---- dv/roc_channel_props.sv ----
// Port-level assertions for the routed output channel.
// Assumes a bind to roc_channel and a single clock domain.
`timescale 1ns/1ps
module roc_channel_props (
	input wire logic        core_clk_in,
	input wire logic        resetn_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [7:0]  paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic        channel_enable_in,
	input wire logic        output_enable_in,
	input wire logic        router_in_valid_in,
	input wire logic        router_in_ready_out,
	input wire logic [52:0] router_input_word_in,
	input wire logic        router_out_valid_out,
	input wire logic        router_out_ready_in,
	input wire logic        channel_out
);
	logic       ctl_wr;
	logic       rx_take;
	logic [1:0] mode_q;
	logic       rtr_q;
	logic       sl_q;
	logic       acb0_q;
	logic       racb_q;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	assign ctl_wr  = psel_in && penable_in && pwrite_in
		&& paddr_in == roc_pkg::ADDR_CTRL;
	assign rx_take = router_in_valid_in && router_in_ready_out;
	// ----------
	// Copy of the control fields seen on the bus and of the received action bit 0
	// ----------
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mode_q <= 2'h0;
			rtr_q  <= 1'b0;
			sl_q   <= 1'b0;
			acb0_q <= 1'b0;
			racb_q <= 1'b0;
		end else begin
			if (ctl_wr) begin
				mode_q <= pwdata_in[1:0];
				rtr_q  <= pwdata_in[roc_pkg::CTRL_RTR_EN];
				sl_q   <= pwdata_in[roc_pkg::CTRL_SL];
				acb0_q <= pwdata_in[roc_pkg::CTRL_ACB_LSB];
			end
			if (rx_take)
				racb_q <= router_input_word_in[roc_pkg::WORD_ACB_LSB];
		end
	end
	property p_rd_upper;
		psel_in && penable_in && !pwrite_in && paddr_in >= roc_pkg::ADDR_CM0
		&& paddr_in <= roc_pkg::ADDR_CNT |-> prdata_out[31:24] == 8'h00;
	endproperty
	a_rd_upper: assert property (p_rd_upper)
		else $error("register read shows bits above 24");
	property p_idle_level;
		!channel_enable_in && !output_enable_in && !ctl_wr
		|=> channel_out == !sl_q;
	endproperty
	a_idle_level: assert property (p_idle_level)
		else $error("idle output is not the inverse of the level bit");
	property p_imm_level;
		mode_q == roc_pkg::MODE_IMMEDIATE && !rtr_q && !ctl_wr
		&& channel_enable_in && output_enable_in
		|=> channel_out == (acb0_q ? sl_q : !sl_q);
	endproperty
	a_imm_level: assert property (p_imm_level)
		else $error("immediate output does not follow action bit 0");
	property p_rtr_level;
		rx_take && !ctl_wr && rtr_q && mode_q == roc_pkg::MODE_IMMEDIATE
		##1 (channel_enable_in && output_enable_in && !ctl_wr && !rx_take)
		|=> channel_out == (racb_q ? sl_q : !sl_q);
	endproperty
	a_rtr_level: assert property (p_rtr_level)
		else $error("output does not follow the received action bit");
	property p_ready_gate;
		router_in_ready_out |-> rtr_q && channel_enable_in;
	endproperty
	a_ready_gate: assert property (p_ready_gate)
		else $error("router input ready while input is disabled");
	property p_out_hold;
		router_out_valid_out && !router_out_ready_in |=> router_out_valid_out;
	endproperty
	a_out_hold: assert property (p_out_hold)
		else $error("router output offer withdrawn before it was taken");
	property p_out_mode;
		$rose(router_out_valid_out) |-> $past(mode_q) == roc_pkg::MODE_COMPARE;
	endproperty
	a_out_mode: assert property (p_out_mode)
		else $error("router output offered outside compare mode");
	property p_reset_clear;
		$rose(resetn_in) |-> !router_out_valid_out && channel_out;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("outputs not in their reset state after reset");
endmodule : roc_channel_props

// ---- dv/roc_router_model.sv ----
// Far side of the channel: routing unit source and sink, time base unit.
// Assumes the bench pushes words into wq and pops taken words from got.
`timescale 1ns/1ps
module roc_router_model (
	input  wire logic        core_clk_in,
	input  wire logic        resetn_in,
	input  wire logic        stall_in,
	output logic      [23:0] time_base_0_out,
	output logic      [23:0] time_base_1_out,
	output logic      [23:0] time_base_2_out,
	output logic             count_tick_out,
	output logic             valid_out,
	input  wire logic        ready_in,
	output logic      [52:0] word_out,
	input  wire logic        rvalid_in,
	output logic             rready_out,
	input  wire logic [52:0] rword_in
);
	logic [52:0] wq[$];
	logic [52:0] got[$];
	logic [52:0] last   = 53'h0;
	logic [52:0] kw     = 53'h0;
	logic [23:0] tick_q = 24'h0;
	logic        take   = 1'b0;
	logic        keep   = 1'b0;
	assign time_base_0_out = tick_q;
	assign time_base_1_out = {1'b0, tick_q[23:1]};
	assign time_base_2_out = ~tick_q;
	// ----------
	// Handshakes
	// ----------
	// Judged at the falling edge, where the combinational ready has
	// settled, so the rising edge never races the channel's flops
	always @(negedge core_clk_in) begin
		take = valid_out && ready_in;
		keep = rvalid_in && rready_out;
		kw   = rword_in;
	end
	// Time bases wrap freely; words are held until taken
	always @(posedge core_clk_in) begin
		if (take)
			last = wq.pop_front();
		tick_q         <= tick_q + 24'h1;
		count_tick_out <= !tick_q[0];
		valid_out      <= resetn_in && wq.size() != 0;
		// An idle word line shows the inverse of the last taken word, not stale data
		word_out       <= (wq.size() != 0) ? wq[0] : ~last;
		rready_out     <= !stall_in;
		if (keep)
			got.push_back(kw);
	end
endmodule : roc_router_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the routed output channel.
// Assumes roc_router_model as far side and an APB master in this bench.
`timescale 1ns/1ps
module tb_top;
	logic        clk = 1'b0, rstn = 1'b0, stall = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        ch_en = 1'b0, out_en = 1'b0, pready, pslverr;
	logic        rx_v, rx_r, tx_v, tx_r, tick, chout;
	logic [23:0] tb0, tb1, tb2;
	logic [52:0] rx_w, tx_w;
	int          errors = 0;
	int          samples_checked = 0;
	int unsigned mdl[7];
	always #10 clk = ~clk;
	roc_channel roc_channel_inst (.core_clk_in(clk), .resetn_in(rstn),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .time_base_0_in(tb0),
		.time_base_1_in(tb1), .time_base_2_in(tb2), .count_tick_in(tick),
		.channel_enable_in(ch_en), .output_enable_in(out_en),
		.router_in_valid_in(rx_v), .router_in_ready_out(rx_r),
		.router_input_word_in(rx_w), .router_out_valid_out(tx_v),
		.router_out_ready_in(tx_r), .router_out_word_out(tx_w),
		.channel_out(chout));
	roc_router_model router_model_inst (.core_clk_in(clk), .resetn_in(rstn),
		.stall_in(stall), .time_base_0_out(tb0), .time_base_1_out(tb1),
		.time_base_2_out(tb2), .count_tick_out(tick), .valid_out(rx_v),
		.ready_in(rx_r), .word_out(rx_w), .rvalid_in(tx_v),
		.rready_out(tx_r), .rword_in(tx_w));
	// ----------
	// Shared tasks
	// ----------
	task automatic chk(input string n, input logic [31:0] s,
			input logic [31:0] x);
		samples_checked++;
		if (s !== x) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] r, output logic e);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		if (a >= roc_pkg::ADDR_CM0 && a <= roc_pkg::ADDR_SR1)
			mdl[a >> 2] = d & 32'h00FFFFFF;
	endtask : wr
	task automatic rd(input string n, input logic [7:0] a,
			input logic [31:0] m, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(n, r & m, x);
	endtask : rd
	task automatic drain();
		int n;
		n = 0;
		while (router_model_inst.wq.size() != 0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk("rx_taken", n < 200, 1);
		repeat (3) @(posedge clk);
	endtask : drain
	task automatic restart(input logic [31:0] c, input logic [31:0] v0,
			input logic [31:0] v1);
		ch_en <= 1'b0;
		@(posedge clk);
		wr(roc_pkg::ADDR_CM0, v0);
		wr(roc_pkg::ADDR_CM1, v1);
		wr(roc_pkg::ADDR_SR0, v0);
		wr(roc_pkg::ADDR_SR1, v1);
		wr(roc_pkg::ADDR_CTRL, c);
		ch_en <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : restart
	task automatic toggles(output int t);
		logic p;
		t = 0;
		p = chout;
		repeat (64) begin
			@(posedge clk);
			if (chout !== p)
				t++;
			p = chout;
		end
	endtask : toggles
	function automatic logic lvl(input logic sl, input logic a0);
		return a0 ? sl : !sl;
	endfunction : lvl
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	// ----------
	// Main sequence and watchdog
	// ----------
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		print_verdict();
	end
	initial begin
		int          t;
		logic [31:0] r, ph;
		logic        e;
		logic [52:0] w;
		logic [23:0] c0;
		t = $urandom(32'h25D7);
		ph = 32'h00070000;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 2; i < 7; i++)
			rd("reset_val", 8'(i * 4), 32'hFFFFFFFF, 32'h0);
		apb(1'b0, 8'h40, 32'h0, r, e);
		chk("unmapped_err", e, 1);
		chk("unmapped_data", r, 0);
		wr(roc_pkg::ADDR_STAT, 32'hFFFFFFFF);
		rd("stat_ro", roc_pkg::ADDR_STAT, 32'h1F, 32'h0);
		for (int i = 2; i < 6; i++)
			wr(8'(i * 4), $urandom());
		for (int i = 2; i < 6; i++)
			rd("reg_width", 8'(i * 4), 32'hFFFFFFFF, mdl[i]);
		$display("test registers done");
		for (int s = 0; s < 2; s++) begin
			wr(roc_pkg::ADDR_CTRL, 32'(s) << roc_pkg::CTRL_SL);
			repeat (2) @(posedge clk);
			chk("idle_level", chout, !s[0]);
		end
		ch_en  <= 1'b1;
		out_en <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			wr(roc_pkg::ADDR_CTRL, 32'({k[1], 4'h0, k[0], 3'h0}));
			repeat (2) @(posedge clk);
			chk("imm_level", chout, lvl(k[1], k[0]));
		end
		$display("test levels done");
		wr(roc_pkg::ADDR_CTRL, 32'h104);
		for (int j = 0; j < 3; j++) begin
			w = 53'({$urandom(), $urandom()});
			router_model_inst.wq.push_back(w);
			drain();
			chk("rtr_level", chout, lvl(1'b1, w[48]));
			rd("sr0", roc_pkg::ADDR_SR0, 32'hFFFFFFFF, 32'(w[23:0]));
			rd("sr1", roc_pkg::ADDR_SR1, 32'hFFFFFFFF, 32'(w[47:24]));
			rd("action_control_in", roc_pkg::ADDR_STAT, 32'h1F, 32'(w[52:48]));
		end
		wr(roc_pkg::ADDR_CTRL, 32'h100);
		router_model_inst.wq.push_back(53'({$urandom(), $urandom()}));
		repeat (8) @(posedge clk);
		rd("gated", roc_pkg::ADDR_SR0, 32'hFFFFFFFF, 32'(w[23:0]));
		w = router_model_inst.wq[0];
		wr(roc_pkg::ADDR_CTRL, 32'h104);
		drain();
		rd("ungated", roc_pkg::ADDR_SR0, 32'hFFFFFFFF, 32'(w[23:0]));
		$display("test router input done");
		restart(32'h5, 32'h0, 32'h0);
		rd("fetch", roc_pkg::ADDR_STAT, ph, 32'(roc_pkg::PH_FETCH) << 16);
		// Target well ahead but within half the time base range
		c0 = router_model_inst.tick_q + 24'h12C;
		w = {5'h05, c0 + 24'h12C, c0};
		stall <= 1'b1;
		router_model_inst.wq.push_back(w);
		drain();
		chk("no_early", tx_v, 0);
		rd("cm0", roc_pkg::ADDR_CM0, 32'hFFFFFFFF, 32'(c0));
		rd("cm1", roc_pkg::ADDR_CM1, 32'hFFFFFFFF, 32'(w[47:24]));
		rd("run", roc_pkg::ADDR_STAT, ph, 32'(roc_pkg::PH_RUN) << 16);
		t = 0;
		while (tx_v !== 1'b1 && t < 1000) begin
			@(posedge clk);
			t++;
		end
		chk("match_time", (tb0 - c0) < 24'h8, 1);
		repeat (5) @(posedge clk);
		stall <= 1'b0;
		repeat (4) @(posedge clk);
		chk("tx_count", router_model_inst.got.size(), 1);
		w = router_model_inst.got.pop_front();
		chk("cap_pair", w[47:24], w[23:0] >> 1);
		chk("cap_time", (w[23:0] - c0) < 24'h8, 1);
		$display("test compare done");
		restart(32'h106, 32'h8, 32'h3);
		rd("pwm_run", roc_pkg::ADDR_STAT, ph, 32'(roc_pkg::PH_RUN) << 16);
		toggles(t);
		chk("pwm_toggles", t > 3, 1);
		restart(32'h7, 32'h7, 32'h5A);
		rd("ser_run", roc_pkg::ADDR_STAT, ph, 32'(roc_pkg::PH_RUN) << 16);
		toggles(t);
		chk("ser_toggles", t > 3, 1);
		$display("test pwm and serial done");
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rd("cnt_reset", roc_pkg::ADDR_CNT, 32'hFFFFFFFF, 32'h0);
		rd("cm1_reset", roc_pkg::ADDR_CM1, 32'hFFFFFFFF, 32'h0);
		$display("test second reset done");
		print_verdict();
	end
endmodule : tb_top
bind roc_channel roc_channel_props roc_channel_props_inst (.*);

// ---- logic/roc_channel.sv ----
// One routed timer output channel: counter, compare and shadow registers,
// two signed compare units, output level unit and router interface.
// Assumes time bases and the counting tick are synchronous to core_clk_in.
//
// Function
// - Counter, both compare and both shadow registers are 24 bits.
// - Compare units do signed ge or le compare against time base 0/1.
// - A control bit selects time base 2 for comparison when present.
// - In compare mode a match may enable or disable the other unit.
// - Channel or output disabled drives inverse of signal level bit.
// - Action bits come from control when router off, router when on.
// - Immediate and compare levels use signal level and action bits.
// - PWM timing from match triggers; signal level gives duty level.
// - Serial mode shifts out the pattern held in compare register 1.
// - Router read in immediate, PWM, serial; compare mode also writes.
// - Enabled with compare and shadow registers zero, router on, not immediate mode: fetch first.
// - PWM with compare 0 or shadow 0 nonzero counts at once.
// - Serial with compare 0 or shadow 0 nonzero shifts at once.
// - Router word splits into shadow 0, shadow 1 and action bits.
// - Shadow to compare transfer never mixes old and new values.
// - Compare mode router word goes straight into compare registers.
// - Compare match captures both time bases into shadow registers.
// - Compare mode offers time stamps and status back to router.
// - Action bit 0 high drives signal level, low drives inverse.
// - Router input enable bit gates the router input stream.
`timescale 1ns/1ps
module roc_channel #(
	parameter int unsigned HAS_TB2 = 1
) (
	input  wire logic                         core_clk_in,
	input  wire logic                         resetn_in,
	input  wire logic                         psel_in,
	input  wire logic                         penable_in,
	input  wire logic                         pwrite_in,
	input  wire logic [7:0]                   paddr_in,
	input  wire logic [31:0]                  pwdata_in,
	output logic      [31:0]                  prdata_out,
	output logic                              pready_out,
	output logic                              pslverr_out,
	input  wire logic [roc_pkg::REG_W-1:0]    time_base_0_in,
	input  wire logic [roc_pkg::REG_W-1:0]    time_base_1_in,
	input  wire logic [roc_pkg::REG_W-1:0]    time_base_2_in,
	input  wire logic                         count_tick_in,
	input  wire logic                         channel_enable_in,
	input  wire logic                         output_enable_in,
	input  wire logic                         router_in_valid_in,
	output logic                              router_in_ready_out,
	input  wire logic [roc_pkg::WORD_W-1:0]   router_input_word_in,
	output logic                              router_out_valid_out,
	input  wire logic                         router_out_ready_in,
	output logic      [roc_pkg::WORD_W-1:0]   router_out_word_out,
	output logic                              channel_out
);
	// ----------
	// Elaboration checks
	// ----------
	if (HAS_TB2 > 1) begin : g_bad_tb2
		$error("HAS_TB2 must be 0 or 1");
	end

	// ----------
	// Reset release
	// ----------
	logic rst_sync1_q;
	logic rst_sync2_q;

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_sync1_q <= 1'b0;
			rst_sync2_q <= 1'b0;
		end else begin
			rst_sync1_q <= 1'b1;
			rst_sync2_q <= rst_sync1_q;
		end
	end

	// ----------
	// Helpers
	// ----------
	// Difference sign makes the compare survive a time base wraparound,
	// provided software keeps targets within half the range.
	function automatic logic cmp_hit(input logic [roc_pkg::REG_W-1:0] tb,
			input logic [roc_pkg::REG_W-1:0] cm, input logic le);
		logic [roc_pkg::REG_W-1:0] diff;
		diff = tb - cm;
		if (le)
			cmp_hit = diff[roc_pkg::REG_W-1] ||
				(diff == '0);
		else
			cmp_hit = !diff[roc_pkg::REG_W-1];
	endfunction : cmp_hit

	// Output level from action bit 0 and the signal level bit
	function automatic logic act_level(input logic sl, input logic acb0);
		act_level = acb0 ? sl : !sl;
	endfunction : act_level

	// ----------
	// State
	// ----------
	roc_pkg::roc_state_type s_q;
	roc_pkg::roc_state_type s_d;

	logic                        wr_acc;
	logic                        rd_setup;
	logic                        rx_ready;
	logic                        rx_fire;
	logic                        tx_fire;
	logic                        start;
	logic                        all_zero;
	logic [roc_pkg::ACB_W-1:0]   acb_eff;
	logic [roc_pkg::REG_W-1:0]   tb_sel;
	logic                        hit0;
	logic                        hit1;
	logic [roc_pkg::REG_W-1:0]   w_lo;
	logic [roc_pkg::REG_W-1:0]   w_hi;
	logic [roc_pkg::ACB_W-1:0]   w_acb;

	assign w_lo  =
		router_input_word_in[roc_pkg::WORD_LO_LSB +: roc_pkg::REG_W];
	assign w_hi  =
		router_input_word_in[roc_pkg::WORD_HI_LSB +: roc_pkg::REG_W];
	assign w_acb =
		router_input_word_in[roc_pkg::WORD_ACB_LSB +: roc_pkg::ACB_W];

	assign wr_acc   = psel_in && penable_in && pwrite_in;
	assign rd_setup = psel_in && !penable_in;

	// Compare mode holds input while a capture waits to be sent, so a new
	// compare pair cannot overrun stamps that were not yet delivered.
	assign rx_ready = s_q.router_en && channel_enable_in &&
		!((s_q.mode == roc_pkg::MODE_COMPARE) && s_q.tx_pend);
	assign rx_fire  = rx_ready && router_in_valid_in;
	assign tx_fire  = s_q.tx_pend && router_out_ready_in;
	assign start    = channel_enable_in && !s_q.en_prev;
	assign all_zero = (s_q.cm0 == '0) && (s_q.cm1 == '0) &&
		(s_q.sr0 == '0) && (s_q.sr1 == '0);
	assign acb_eff  = s_q.router_en ? s_q.action_control_in :
		s_q.acb;

	// Time base 2 select wins over time base 1 select
	always_comb begin
		if (s_q.tb2_sel && (HAS_TB2 == 1))
			tb_sel = time_base_2_in;
		else if (s_q.tb_sel)
			tb_sel = time_base_1_in;
		else
			tb_sel = time_base_0_in;
	end

	assign hit0 = s_q.unit_en[0] &&
		cmp_hit(tb_sel, s_q.cm0, s_q.le_sel);
	assign hit1 = s_q.unit_en[1] &&
		cmp_hit(tb_sel, s_q.cm1, s_q.le_sel);

	// ----------
	// Next state
	// ----------
	always_comb begin
		s_d = s_q;
		s_d.en_prev = channel_enable_in;

		// APB read data is prepared in the setup cycle
		if (rd_setup) begin
			s_d.pslverr = 1'b0;
			s_d.prdata  = 32'h0000_0000;
			unique case (paddr_in)
				roc_pkg::ADDR_CTRL: begin
					s_d.prdata[roc_pkg::CTRL_MODE_LSB +: 2] = s_q.mode;
					s_d.prdata[roc_pkg::CTRL_RTR_EN]  = s_q.router_en;
					s_d.prdata[roc_pkg::CTRL_ACB_LSB +: roc_pkg::ACB_W] =
						s_q.acb;
					s_d.prdata[roc_pkg::CTRL_SL]      = s_q.sl;
					s_d.prdata[roc_pkg::CTRL_TB_SEL]  = s_q.tb_sel;
					s_d.prdata[roc_pkg::CTRL_TB2_SEL] = s_q.tb2_sel;
					s_d.prdata[roc_pkg::CTRL_LE_SEL]  = s_q.le_sel;
					s_d.prdata[roc_pkg::CTRL_MSB_1ST] = s_q.msb_first;
				end
				roc_pkg::ADDR_STAT: begin
					s_d.prdata[roc_pkg::STAT_ACTION_CONTROL_IN_LSB +: roc_pkg::ACB_W] =
						s_q.action_control_in;
					s_d.prdata[roc_pkg::STAT_ACTION_CONTROL_OUT_LSB +: roc_pkg::ACB_W] =
						s_q.action_control_out;
					s_d.prdata[roc_pkg::STAT_PH_LSB +: 3]   = s_q.phase;
					s_d.prdata[roc_pkg::STAT_UNIT_LSB +: 2] = s_q.unit_en;
					s_d.prdata[roc_pkg::STAT_LEVEL]         = s_q.level;
					s_d.prdata[roc_pkg::STAT_TX_PEND]       = s_q.tx_pend;
				end
				roc_pkg::ADDR_CM0: s_d.prdata[roc_pkg::REG_W-1:0] = s_q.cm0;
				roc_pkg::ADDR_CM1: s_d.prdata[roc_pkg::REG_W-1:0] = s_q.cm1;
				roc_pkg::ADDR_SR0: s_d.prdata[roc_pkg::REG_W-1:0] = s_q.sr0;
				roc_pkg::ADDR_SR1: s_d.prdata[roc_pkg::REG_W-1:0] = s_q.sr1;
				roc_pkg::ADDR_CNT: s_d.prdata[roc_pkg::REG_W-1:0] = s_q.cn0;
				default: s_d.pslverr = 1'b1;
			endcase
		end

		// APB writes take effect at the access edge
		if (wr_acc) begin
			unique case (paddr_in)
				roc_pkg::ADDR_CTRL: begin
					s_d.mode      = pwdata_in[roc_pkg::CTRL_MODE_LSB +: 2];
					s_d.router_en = pwdata_in[roc_pkg::CTRL_RTR_EN];
					s_d.acb       =
						pwdata_in[roc_pkg::CTRL_ACB_LSB +: roc_pkg::ACB_W];
					s_d.sl        = pwdata_in[roc_pkg::CTRL_SL];
					s_d.tb_sel    = pwdata_in[roc_pkg::CTRL_TB_SEL];
					s_d.tb2_sel   = pwdata_in[roc_pkg::CTRL_TB2_SEL];
					s_d.le_sel    = pwdata_in[roc_pkg::CTRL_LE_SEL];
					s_d.msb_first = pwdata_in[roc_pkg::CTRL_MSB_1ST];
					// Software arms the compare units when router is off
					if (!pwdata_in[roc_pkg::CTRL_RTR_EN]) begin
						s_d.unit_en[0] = pwdata_in[roc_pkg::CTRL_ACB_LSB +
							roc_pkg::ACB_UNIT0];
						s_d.unit_en[1] = pwdata_in[roc_pkg::CTRL_ACB_LSB +
							roc_pkg::ACB_UNIT1];
					end
				end
				roc_pkg::ADDR_CM0: s_d.cm0 = pwdata_in[roc_pkg::REG_W-1:0];
				roc_pkg::ADDR_CM1: s_d.cm1 = pwdata_in[roc_pkg::REG_W-1:0];
				roc_pkg::ADDR_SR0: s_d.sr0 = pwdata_in[roc_pkg::REG_W-1:0];
				roc_pkg::ADDR_SR1: s_d.sr1 = pwdata_in[roc_pkg::REG_W-1:0];
				roc_pkg::ADDR_CNT: s_d.cn0 = pwdata_in[roc_pkg::REG_W-1:0];
				default: ;
			endcase
		end

		// A match in the same cycle sets it again below: set wins
		if (tx_fire)
			s_d.tx_pend = 1'b0;

		// Phase control
		unique case (s_q.phase)
			roc_pkg::PH_IDLE: begin
				if (start) begin
					// Counter restarts from zero on each enable
					s_d.cn0 = '0;
					if (s_q.router_en && all_zero &&
							(s_q.mode != roc_pkg::MODE_IMMEDIATE))
						s_d.phase = roc_pkg::PH_FETCH;
					else
						s_d.phase = roc_pkg::PH_RUN;
				end
			end
			roc_pkg::PH_FETCH: begin
				if (!channel_enable_in)
					s_d.phase = roc_pkg::PH_IDLE;
				else if (rx_fire)
					s_d.phase = roc_pkg::PH_RUN;
			end
			roc_pkg::PH_RUN: begin
				if (!channel_enable_in)
					s_d.phase = roc_pkg::PH_IDLE;
			end
			default: s_d.phase = roc_pkg::PH_IDLE;
		endcase

		// Signal generation
		if (s_q.phase == roc_pkg::PH_RUN) begin
			unique case (s_q.mode)
				roc_pkg::MODE_IMMEDIATE:
					s_d.level = act_level(s_q.sl,
						acb_eff[roc_pkg::ACB_LEVEL]);
				roc_pkg::MODE_COMPARE: begin
					if (hit0 || hit1) begin
						s_d.sr0 = time_base_0_in;
						s_d.sr1 = time_base_1_in;
						s_d.action_control_out = {acb_eff[4:2], hit1, hit0};
						s_d.tx_pend = s_q.router_en;
						s_d.level = acb_eff[roc_pkg::ACB_TOGGLE] ? !s_q.level :
							act_level(s_q.sl,
							acb_eff[roc_pkg::ACB_LEVEL]);
						s_d.unit_en = s_q.unit_en & ~{hit1, hit0};
						// Match trigger of unit 0 hands over to unit 1; unit 1's match disables unit 0
						if (acb_eff[roc_pkg::ACB_COMBINE]) begin
							if (hit0)
								s_d.unit_en[1] = 1'b1;
							if (hit1)
								s_d.unit_en[0] = 1'b0;
						end
					end
				end
				roc_pkg::MODE_PWM: begin
					if (count_tick_in) begin
						if (s_q.cn0 >= s_q.cm0) begin
							// Period end: both shadows move in one edge, and a
							// router write in that edge lands in the shadows
							// only, so the pair is never mixed.
							s_d.cn0 = '0;
							s_d.cm0 = s_q.sr0;
							s_d.cm1 = s_q.sr1;
							s_d.level = s_q.sl;
						end else begin
							s_d.cn0 = s_q.cn0 + 1'b1;
							if (s_q.cn0 + 1'b1 == s_q.cm1)
								s_d.level = !s_q.sl;
						end
					end
				end
				roc_pkg::MODE_SERIAL: begin
					if (count_tick_in) begin
						s_d.level = s_q.msb_first ? s_q.cm1[roc_pkg::REG_W-1] :
							s_q.cm1[0];
						s_d.cm1 = s_q.msb_first ?
							{s_q.cm1[roc_pkg::REG_W-2:0], 1'b0} :
							{1'b0, s_q.cm1[roc_pkg::REG_W-1:1]};
						if (s_q.cn0 >= s_q.cm0) begin
							s_d.cn0 = '0;
							s_d.cm0 = s_q.sr0;
							s_d.cm1 = s_q.sr1;
						end else begin
							s_d.cn0 = s_q.cn0 + 1'b1;
						end
					end
				end
			endcase
		end

		// Router input word, taken only while enabled
		if (rx_fire) begin
			s_d.action_control_in = w_acb;
			if (s_q.mode == roc_pkg::MODE_COMPARE) begin
				// The word's action bits rearm the compare units
				s_d.cm0 = w_lo;
				s_d.cm1 = w_hi;
				s_d.unit_en = {w_acb[roc_pkg::ACB_UNIT1],
					w_acb[roc_pkg::ACB_UNIT0]};
			end else if (s_q.phase == roc_pkg::PH_FETCH) begin
				// First word of a start goes to the pair in use as well
				s_d.sr0 = w_lo;
				s_d.sr1 = w_hi;
				s_d.cm0 = w_lo;
				s_d.cm1 = w_hi;
				s_d.cn0 = '0;
			end else begin
				s_d.sr0 = w_lo;
				s_d.sr1 = w_hi;
			end
		end

		// Disabled channel or output parks at the inverse level
		if (!channel_enable_in || !output_enable_in)
			s_d.level = !s_d.sl;
	end

	// Every state flop leaves reset on the same synchronised edge
	always_ff @(posedge core_clk_in or negedge rst_sync2_q) begin
		if (!rst_sync2_q) begin
			s_q         <= '0;
			s_q.phase   <= roc_pkg::PH_IDLE;
			s_q.level   <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------
	// Outputs
	// ----------
	// Ready is a plain decode: a word is taken in the cycle it shows
	assign prdata_out           = s_q.prdata;
	assign pslverr_out          = s_q.pslverr;
	assign pready_out           = 1'b1;
	assign router_in_ready_out  = rx_ready;
	assign router_out_valid_out = s_q.tx_pend;
	assign router_out_word_out  = {s_q.action_control_out, s_q.sr1, s_q.sr0};
	assign channel_out          = s_q.level;
endmodule : roc_channel

// ---- logic/roc_pkg.sv ----
// Constants, register map and state types of the routed output channel.
// Assumes a 32-bit APB slave with one register per aligned word.
package roc_pkg;
	// ----------
	// Widths
	// ----------
	localparam int unsigned REG_W  = 24;
	localparam int unsigned WORD_W = 53;
	localparam int unsigned ACB_W  = 5;

	// ----------
	// Register byte offsets
	// ----------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_CM0  = 8'h08;
	localparam logic [7:0] ADDR_CM1  = 8'h0C;
	localparam logic [7:0] ADDR_SR0  = 8'h10;
	localparam logic [7:0] ADDR_SR1  = 8'h14;
	localparam logic [7:0] ADDR_CNT  = 8'h18;

	// ----------
	// Control register fields
	// ----------
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_RTR_EN   = 2;
	localparam int unsigned CTRL_ACB_LSB  = 3;
	localparam int unsigned CTRL_SL       = 8;
	localparam int unsigned CTRL_TB_SEL   = 9;
	localparam int unsigned CTRL_TB2_SEL  = 10;
	localparam int unsigned CTRL_LE_SEL   = 11;
	localparam int unsigned CTRL_MSB_1ST  = 12;

	// ----------
	// Status register fields
	// ----------
	localparam int unsigned STAT_ACTION_CONTROL_IN_LSB = 0;
	localparam int unsigned STAT_ACTION_CONTROL_OUT_LSB = 8;
	localparam int unsigned STAT_PH_LSB   = 16;
	localparam int unsigned STAT_UNIT_LSB = 19;
	localparam int unsigned STAT_LEVEL    = 21;
	localparam int unsigned STAT_TX_PEND  = 22;

	// ----------
	// Router word fields
	// ----------
	localparam int unsigned WORD_LO_LSB  = 0;
	localparam int unsigned WORD_HI_LSB  = 24;
	localparam int unsigned WORD_ACB_LSB = 48;

	// ----------
	// Action control bit positions
	// ----------
	localparam int unsigned ACB_LEVEL   = 0;
	localparam int unsigned ACB_TOGGLE  = 1;
	localparam int unsigned ACB_UNIT0   = 2;
	localparam int unsigned ACB_UNIT1   = 3;
	localparam int unsigned ACB_COMBINE = 4;

	// ----------
	// Modes and phases
	// ----------
	localparam logic [1:0] MODE_IMMEDIATE = 2'h0;
	localparam logic [1:0] MODE_COMPARE   = 2'h1;
	localparam logic [1:0] MODE_PWM       = 2'h2;
	localparam logic [1:0] MODE_SERIAL    = 2'h3;

	typedef enum logic [2:0] {
		PH_IDLE  = 3'h1,
		PH_FETCH = 3'h2,
		PH_RUN   = 3'h4
	} roc_phase_type;

	typedef struct packed {
		logic [1:0]        mode;
		logic              router_en;
		logic [ACB_W-1:0]  acb;
		logic              sl;
		logic              tb_sel;
		logic              tb2_sel;
		logic              le_sel;
		logic              msb_first;
		logic [REG_W-1:0]  cn0;
		logic [REG_W-1:0]  cm0;
		logic [REG_W-1:0]  cm1;
		logic [REG_W-1:0]  sr0;
		logic [REG_W-1:0]  sr1;
		logic [ACB_W-1:0]  action_control_in;
		logic [ACB_W-1:0]  action_control_out;
		roc_phase_type     phase;
		logic [1:0]        unit_en;
		logic              level;
		logic              tx_pend;
		logic              en_prev;
		logic [31:0]       prdata;
		logic              pslverr;
	} roc_state_type;
endpackage : roc_pkg
